// [hw/alsicp_top.sv]
// i2c target command port of the ambient light sensor
`timescale 1ns/100ps
module alsicp_top #(
  parameter logic [6:0] TARGET = alsicp_pkg::TARGET_ADDR
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] sample_data_i,
  input wire logic sample_done_i,
  output alsicp_pkg::alsicp_meas_cfg_type meas_cfg_o,
  output alsicp_pkg::alsicp_trim_cfg_type trim_cfg_o
);

  // state on the rising edge of the bus clock
  typedef struct packed {
    alsicp_pkg::alsicp_link_state_type state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic addr_hit;
    logic rd_low;
    logic [15:0] rd_word;
  } alsicp_rise_type;

  // command capture on the bus clock; cleared only by the system reset
  // so a frame reset can never fake a command toggle
  typedef struct packed {
    logic [7:0] cmd_byte;
    logic cmd_tgl;
  } alsicp_cmd_type;

  // state on the falling edge of the bus clock
  typedef struct packed {
    logic sda_oe;
    logic sda_out;
  } alsicp_fall_type;

  // state on the system clock
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic link_rst;
    logic release_arm;
    logic [1:0] cmd_sync;
    logic cmd_d;
    logic active;
    logic manual_mode;
    alsicp_pkg::alsicp_meas_cmd_type meas_cmd;
    alsicp_pkg::alsicp_trim_cmd_type trim_cmd;
    logic [5:0] num;
    logic [5:0] den;
    logic [15:0] pend_word;
    logic pend_valid;
    logic [15:0] result_word;
  } alsicp_sys_type;

  alsicp_rise_type rise;
  alsicp_rise_type next_rise;
  alsicp_cmd_type cmd;
  alsicp_cmd_type next_cmd;
  alsicp_fall_type fall;
  alsicp_fall_type next_fall;
  alsicp_sys_type sys;
  alsicp_sys_type next_sys;

  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [2:0] tx_index;
  logic start_seen;
  logic stop_seen;
  logic cmd_event;
  alsicp_pkg::alsicp_meas_cmd_type new_meas;
  alsicp_pkg::alsicp_trim_cmd_type new_trim;

  // numerator of the sensitivity scale
  function automatic logic [5:0] trim_num(input logic dir,
                                          input logic [4:0] step);
    logic [5:0] twice;
    twice = {step, 1'b0};
    if (step == 5'h00) begin
      trim_num = alsicp_pkg::RATIO_UNITY;
    end else if (dir == alsicp_pkg::TRIM_MINUS) begin
      trim_num = twice;
    end else begin
      trim_num = twice | 6'h01;
    end
  endfunction : trim_num

  // denominator of the sensitivity scale
  function automatic logic [5:0] trim_den(input logic dir,
                                          input logic [4:0] step);
    logic [5:0] twice;
    twice = {step, 1'b0};
    if (step == 5'h00) begin
      trim_den = alsicp_pkg::RATIO_UNITY;
    end else if (dir == alsicp_pkg::TRIM_MINUS) begin
      trim_den = twice | 6'h01;
    end else begin
      trim_den = twice;
    end
  endfunction : trim_den

  // ---- bus clock domain, reset by the frame signal except the command capture ----

  // bus clock samples the data line directly: it is that line's own clock
  assign rx_byte = {rise.shift[6:0], sda_i};

  always_comb begin
    next_rise = rise;
    next_cmd = cmd;
    if (rise.bit_cnt == alsicp_pkg::ACK_SLOT) begin
      next_rise.bit_cnt = alsicp_pkg::BIT_FIRST;
    end else begin
      next_rise.bit_cnt = 4'(rise.bit_cnt + alsicp_pkg::BIT_STEP);
    end
    unique case (rise.state)
      alsicp_pkg::LINK_ADDR: begin
        if (rise.bit_cnt != alsicp_pkg::ACK_SLOT) begin
          next_rise.shift = rx_byte;
        end
        if (rise.bit_cnt == alsicp_pkg::BIT_LAST) begin
          next_rise.addr_hit = (rise.shift[6:0] == TARGET);
        end
        if (rise.bit_cnt == alsicp_pkg::ACK_SLOT) begin
          if (!rise.addr_hit) begin
            next_rise.state = alsicp_pkg::LINK_IGNORE;
          end else if (rise.shift[0] == alsicp_pkg::DIR_READ) begin
            next_rise.state = alsicp_pkg::LINK_READ;
            next_rise.rd_low = 1'b0;
            // one snapshot serves both bytes
            next_rise.rd_word = sys.result_word;
          end else begin
            next_rise.state = alsicp_pkg::LINK_CMD;
          end
        end
      end
      alsicp_pkg::LINK_CMD: begin
        if (rise.bit_cnt != alsicp_pkg::ACK_SLOT) begin
          next_rise.shift = rx_byte;
        end
        if (rise.bit_cnt == alsicp_pkg::BIT_LAST) begin
          // byte held until the next command, far longer than the sync
          next_cmd.cmd_byte = rx_byte;
          next_cmd.cmd_tgl = ~cmd.cmd_tgl;
        end
        if (rise.bit_cnt == alsicp_pkg::ACK_SLOT) begin
          // only one command byte per write; later bytes get no ack
          next_rise.state = alsicp_pkg::LINK_IGNORE;
        end
      end
      alsicp_pkg::LINK_READ: begin
        if (rise.bit_cnt == alsicp_pkg::ACK_SLOT) begin
          if (sda_i || rise.rd_low) begin
            next_rise.state = alsicp_pkg::LINK_IGNORE;
          end else begin
            next_rise.rd_low = 1'b1;
          end
        end
      end
      alsicp_pkg::LINK_IGNORE: begin
        next_rise.shift = rise.shift;
      end
    endcase
  end

  always_ff @(posedge scl_clk_i or posedge sys.link_rst) begin
    if (sys.link_rst) begin
      rise <= '{
        state: alsicp_pkg::LINK_ADDR,
        bit_cnt: alsicp_pkg::BIT_FIRST,
        shift: 8'h00,
        addr_hit: 1'b0,
        rd_low: 1'b0,
        rd_word: 16'h0000
      };
    end else begin
      rise <= next_rise;
    end
  end

  always_ff @(posedge scl_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd <= '{cmd_byte: 8'h00, cmd_tgl: 1'b0};
    end else begin
      cmd <= next_cmd;
    end
  end

  // data line changes only while the bus clock is low
  assign tx_byte = rise.rd_low ? rise.rd_word[7:0] : rise.rd_word[15:8];
  assign tx_index = 3'(alsicp_pkg::BIT_LAST - rise.bit_cnt);

  always_comb begin
    next_fall = fall;
    next_fall.sda_out = 1'b0;
    unique case (rise.state)
      alsicp_pkg::LINK_ADDR: begin
        next_fall.sda_oe = (rise.bit_cnt == alsicp_pkg::ACK_SLOT) &&
                           rise.addr_hit;
      end
      alsicp_pkg::LINK_CMD: begin
        next_fall.sda_oe = (rise.bit_cnt == alsicp_pkg::ACK_SLOT);
      end
      alsicp_pkg::LINK_READ: begin
        // open drain: pull low for a zero, release for a one and for ack
        next_fall.sda_oe = (rise.bit_cnt != alsicp_pkg::ACK_SLOT) &&
                           !tx_byte[tx_index];
      end
      alsicp_pkg::LINK_IGNORE: begin
        next_fall.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(negedge scl_clk_i or posedge sys.link_rst) begin
    if (sys.link_rst) begin
      fall <= '{
        sda_oe: 1'b0,
        sda_out: 1'b0
      };
    end else begin
      fall <= next_fall;
    end
  end

  assign sda_o = fall.sda_out;
  assign sda_oe_o = fall.sda_oe;

  // ---- system clock domain ----

  assign start_seen = sys.scl_d && sys.scl_sync[1] &&
                      sys.sda_d && !sys.sda_sync[1];
  assign stop_seen = sys.scl_d && sys.scl_sync[1] &&
                     !sys.sda_d && sys.sda_sync[1];
  assign cmd_event = sys.cmd_sync[1] ^ sys.cmd_d;
  assign new_meas = alsicp_pkg::alsicp_meas_cmd_type'(cmd.cmd_byte);
  assign new_trim = alsicp_pkg::alsicp_trim_cmd_type'(cmd.cmd_byte);

  always_comb begin
    next_sys = sys;
    next_sys.scl_sync = {sys.scl_sync[0], scl_clk_i};
    next_sys.sda_sync = {sys.sda_sync[0], sda_i};
    next_sys.scl_d = sys.scl_sync[1];
    next_sys.sda_d = sys.sda_sync[1];
    next_sys.cmd_sync = {sys.cmd_sync[0], cmd.cmd_tgl};
    next_sys.cmd_d = sys.cmd_sync[1];
    // frame reset: held between frames, pulsed by a (repeated) start
    next_sys.release_arm = 1'b0;
    if (stop_seen) begin
      next_sys.link_rst = 1'b1;
    end else if (start_seen) begin
      next_sys.link_rst = 1'b1;
      next_sys.release_arm = 1'b1;
    end else if (sys.release_arm) begin
      next_sys.link_rst = 1'b0;
    end
    if (cmd_event) begin
      unique case (new_meas.func)
        alsicp_pkg::FUNC_MEASURE: begin
          next_sys.active = 1'b1;
          next_sys.meas_cmd = new_meas;
        end
        alsicp_pkg::FUNC_SLEEP: begin
          next_sys.active = 1'b0;
        end
        alsicp_pkg::FUNC_TRIM: begin
          next_sys.trim_cmd = new_trim;
        end
        default: begin
          next_sys.active = sys.active;
        end
      endcase
    end
    next_sys.num = trim_num(next_sys.trim_cmd.dir, next_sys.trim_cmd.step);
    next_sys.den = trim_den(next_sys.trim_cmd.dir, next_sys.trim_cmd.step);
    // registered so the output comes straight from a flop
    next_sys.manual_mode =
      (next_sys.meas_cmd.integ == alsicp_pkg::INTEG_MANUAL);
    // result word moves only between frames; a new sample beats the clear
    if (sys.link_rst && sys.pend_valid) begin
      next_sys.result_word = sys.pend_word;
      next_sys.pend_valid = 1'b0;
    end
    if (sample_done_i) begin
      next_sys.pend_word = sample_data_i;
      next_sys.pend_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sys <= '{
        scl_sync: 2'h3,
        sda_sync: 2'h3,
        scl_d: 1'b1,
        sda_d: 1'b1,
        link_rst: 1'b1,
        release_arm: 1'b0,
        cmd_sync: 2'h0,
        cmd_d: 1'b0,
        active: 1'b0,
        manual_mode: 1'b0,
        meas_cmd: alsicp_pkg::MEAS_CMD_RESET,
        trim_cmd: alsicp_pkg::TRIM_CMD_RESET,
        num: alsicp_pkg::RATIO_UNITY,
        den: alsicp_pkg::RATIO_UNITY,
        pend_word: 16'h0000,
        pend_valid: 1'b0,
        result_word: 16'h0000
      };
    end else begin
      sys <= next_sys;
    end
  end

  assign meas_cfg_o.active = sys.active;
  assign meas_cfg_o.gain = sys.meas_cmd.gain;
  assign meas_cfg_o.integ = sys.meas_cmd.integ;
  assign meas_cfg_o.manual_mode = sys.manual_mode;
  assign meas_cfg_o.manual_stop = sys.meas_cmd.manual;
  assign trim_cfg_o.dir = sys.trim_cmd.dir;
  assign trim_cfg_o.step = sys.trim_cmd.step;
  assign trim_cfg_o.num = sys.num;
  assign trim_cfg_o.den = sys.den;

endmodule : alsicp_top

// [common/alsicp_pkg.sv]
// constants, command layouts and state types for the light sensor i2c port
package alsicp_pkg;

  // target address and direction bit
  localparam logic [6:0] TARGET_ADDR = 7'h13;
  localparam logic DIR_READ = 1'h1;

  // function select codes in the two top bits of a command byte
  localparam logic [1:0] FUNC_SLEEP = 2'h0;
  localparam logic [1:0] FUNC_TRIM = 2'h2;
  localparam logic [1:0] FUNC_MEASURE = 2'h3;

  // gain codes: x0.25, x1, x2, x8
  localparam logic [1:0] GAIN_QUARTER = 2'h0;
  localparam logic [1:0] GAIN_ONE = 2'h1;
  localparam logic [1:0] GAIN_TWO = 2'h2;
  localparam logic [1:0] GAIN_EIGHT = 2'h3;

  // integration codes: 12.5 ms, 100 ms, 200 ms, manual
  localparam logic [1:0] INTEG_12P5MS = 2'h0;
  localparam logic [1:0] INTEG_100MS = 2'h1;
  localparam logic [1:0] INTEG_200MS = 2'h2;
  localparam logic [1:0] INTEG_MANUAL = 2'h3;

  // manual bit: 0 starts, 1 stops
  localparam logic MANUAL_START = 1'h0;
  localparam logic MANUAL_STOP = 1'h1;

  // trim direction: 0 reduces, 1 raises
  localparam logic TRIM_MINUS = 1'h0;
  localparam logic TRIM_PLUS = 1'h1;

  // reset values of the write-only command registers
  localparam logic [7:0] MEAS_CMD_RESET = 8'h2c;
  localparam logic [7:0] TRIM_CMD_RESET = 8'h00;

  // bit positions within a nine-clock byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // unity ratio used for a zero trim step
  localparam logic [5:0] RATIO_UNITY = 6'h01;

  // measurement command byte layout, bit 7 first
  typedef struct packed {
    logic [1:0] func;
    logic spare;
    logic [1:0] gain;
    logic [1:0] integ;
    logic manual;
  } alsicp_meas_cmd_type;

  // sensitivity trim command byte layout, bit 7 first
  typedef struct packed {
    logic [1:0] func;
    logic dir;
    logic [4:0] step;
  } alsicp_trim_cmd_type;

  // measurement settings presented to the converter
  typedef struct packed {
    logic active;
    logic [1:0] gain;
    logic [1:0] integ;
    logic manual_mode;
    logic manual_stop;
  } alsicp_meas_cfg_type;

  // sensitivity scale as numerator over denominator
  typedef struct packed {
    logic dir;
    logic [4:0] step;
    logic [5:0] num;
    logic [5:0] den;
  } alsicp_trim_cfg_type;

  typedef enum logic [1:0] {
    LINK_ADDR = 2'b00,
    LINK_CMD = 2'b01,
    LINK_READ = 2'b10,
    LINK_IGNORE = 2'b11
  } alsicp_link_state_type;

endpackage : alsicp_pkg

// [bench/alsicp_checker.sv]
// assertion checker for the light sensor i2c port
`timescale 1ns/100ps
module alsicp_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic scl_clk_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input alsicp_pkg::alsicp_meas_cfg_type meas_cfg_o,
  input alsicp_pkg::alsicp_trim_cfg_type trim_cfg_o
);
  logic [3:0] scl_hi_cnt;
  // scl high far longer than a bit phase means an idle bus
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_hi_cnt <= 4'h0;
    end else if (!scl_clk_i) begin
      scl_hi_cnt <= 4'h0;
    end else if (scl_hi_cnt != 4'hf) begin
      scl_hi_cnt <= scl_hi_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  a_drive_low_only: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_ack_scl_low: assert property (
    $rose(sda_oe_o) |-> !scl_clk_i)
    else $error("sda drive began with scl high");
  a_idle_release: assert property (
    scl_hi_cnt == 4'hf |-> !sda_oe_o)
    else $error("sda driven on idle bus");
  a_manual_flag: assert property (meas_cfg_o.manual_mode ==
    (meas_cfg_o.integ == alsicp_pkg::INTEG_MANUAL))
    else $error("manual mode flag wrong");
  a_trim_minus: assert property (trim_cfg_o.step != 5'h0 &&
    !trim_cfg_o.dir |-> trim_cfg_o.num == {trim_cfg_o.step, 1'b0} &&
    trim_cfg_o.den == {trim_cfg_o.step, 1'b1})
    else $error("minus trim ratio wrong");
  a_trim_plus: assert property (trim_cfg_o.step != 5'h0 &&
    trim_cfg_o.dir |-> trim_cfg_o.num == {trim_cfg_o.step, 1'b1} &&
    trim_cfg_o.den == {trim_cfg_o.step, 1'b0})
    else $error("plus trim ratio wrong");
  a_trim_unity: assert property (trim_cfg_o.step == 5'h0 |->
    trim_cfg_o.num == 6'h01 && trim_cfg_o.den == 6'h01)
    else $error("zero step not unity");
  a_reset_meas: assert property ($past(sys_rst_i) |->
    !meas_cfg_o.active && meas_cfg_o.gain == alsicp_pkg::GAIN_ONE &&
    meas_cfg_o.integ == alsicp_pkg::INTEG_200MS && !meas_cfg_o.manual_stop)
    else $error("measurement fields wrong after reset");
  a_sleep_keep: assert property ($fell(meas_cfg_o.active) |->
    $stable(meas_cfg_o.gain) && $stable(meas_cfg_o.integ))
    else $error("sleep changed settings");
endmodule : alsicp_checker

bind alsicp_top alsicp_checker i_alsicp_checker (
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .scl_clk_i(scl_clk_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .meas_cfg_o(meas_cfg_o),
  .trim_cfg_o(trim_cfg_o)
);

// [bench/alsicp_ctl.sv]
// i2c controller model facing the light sensor port
`timescale 1ns/100ps
module alsicp_ctl (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // scl stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic start_frame();
    sda_oe_o = 1'b1;
    // long hold lets the port's frame reset release first
    #200 scl_o = 1'b0;
  endtask : start_frame
  task automatic stop_frame();
    #40 sda_oe_o = 1'b1;
    #40 scl_o = 1'b1;
    #80 sda_oe_o = 1'b0;
    #400;
  endtask : stop_frame
  task automatic xfer_bit(input logic b, output logic s);
    #40 sda_oe_o = !b;
    #40 scl_o = 1'b1;
    #40 s = sda_i;
    #40 scl_o = 1'b0;
  endtask : xfer_bit
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], s);
    end
    xfer_bit(1'b1, s);
    ack = !s;
  endtask : write_byte
  task automatic read_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      b[i] = s;
    end
    xfer_bit(!ack, s);
  endtask : read_byte
endmodule : alsicp_ctl

// [bench/alsicp_top_bench.sv]
// testbench of the light sensor i2c port
`timescale 1ns/100ps
module alsicp_top_bench;
  localparam logic [6:0] TGT = alsicp_pkg::TARGET_ADDR;
  logic clk, rst, scl, sda, dev_oe, dev_do, ctl_oe, done;
  logic [15:0] sample;
  logic [15:0] w;
  logic [1:0] ak;
  alsicp_pkg::alsicp_meas_cfg_type meas;
  alsicp_pkg::alsicp_trim_cfg_type trim;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // open drain wire with pull-up
  assign sda = !(dev_oe || ctl_oe);
  alsicp_top i_alsicp_top (.clock_i(clk), .sys_rst_i(rst), .scl_clk_i(scl),
    .sda_i(sda), .sda_o(dev_do), .sda_oe_o(dev_oe), .sample_data_i(sample),
    .sample_done_i(done), .meas_cfg_o(meas), .trim_cfg_o(trim));
  alsicp_ctl i_alsicp_ctl (.sda_i(sda), .scl_o(scl), .sda_oe_o(ctl_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [17:0] exp,
    input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic send_cmd(input logic [6:0] a, input logic [7:0] c);
    i_alsicp_ctl.start_frame();
    i_alsicp_ctl.write_byte({a, 1'b0}, ak[1]);
    i_alsicp_ctl.write_byte(c, ak[0]);
    i_alsicp_ctl.stop_frame();
  endtask : send_cmd
  task automatic pulse(input logic [15:0] v);
    @(negedge clk);
    sample = v;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask : pulse
  // a nonzero mid value lands a new sample between the two bytes
  task automatic read_word(input logic [15:0] mid);
    i_alsicp_ctl.start_frame();
    i_alsicp_ctl.write_byte({TGT, alsicp_pkg::DIR_READ}, ak[1]);
    i_alsicp_ctl.read_byte(1'b1, w[15:8]);
    if (mid != 16'h0) begin
      pulse(mid);
    end
    i_alsicp_ctl.read_byte(1'b0, w[7:0]);
    i_alsicp_ctl.stop_frame();
  endtask : read_word
  task automatic t_reset();
    chk("meas rst", {1'h0, 2'h1, 2'h2, 2'h0}, meas);
    chk("trim rst", {1'h0, 5'h0, 6'h1, 6'h1}, trim);
  endtask : t_reset
  task automatic t_measure();
    logic [7:0] c [5] = '{8'hc6, 8'hcd, 8'hd2, 8'hd9, 8'hcf};
    foreach (c[k]) begin
      send_cmd(TGT, c[k]);
      chk("cmd ack", 2'h3, ak);
      chk("meas", {1'b1, c[k][4:3], c[k][2:1],
        c[k][2:1] == alsicp_pkg::INTEG_MANUAL, c[k][0]}, meas);
    end
  endtask : t_measure
  task automatic t_sleep();
    send_cmd(TGT, 8'h3f);
    chk("sleep", {1'h0, 2'h1, 2'h3, 1'h1, 1'h1}, meas);
    chk("trim kept", {1'h0, 5'h0, 6'h1, 6'h1}, trim);
  endtask : t_sleep
  task automatic t_trim();
    logic [5:0] c [6] = '{6'h01, 6'h0a, 6'h26, 6'h21, 6'h3f, 6'h00};
    logic [5:0] n2, num, den;
    foreach (c[k]) begin
      send_cmd(TGT, {alsicp_pkg::FUNC_TRIM, c[k]});
      n2 = {c[k][4:0], 1'b0};
      num = n2 + 6'(c[k][5]);
      den = n2 + 6'(!c[k][5]);
      if (n2 == 6'h0) begin
        num = 6'h1;
        den = 6'h1;
      end
      chk("trim", {c[k], num, den},
        trim);
    end
  endtask : t_trim
  task automatic t_read();
    pulse(16'h2481);
    repeat (4) @(negedge clk);
    read_word(16'h0);
    chk("read ack", 1'b1, ak[1]);
    chk("word", 16'h2481, w);
    read_word(16'h5a3c);
    chk("snapshot", 16'h2481, w);
    read_word(16'h0);
    chk("newest", 16'h5a3c, w);
  endtask : t_read
  task automatic t_foreign();
    send_cmd(7'h12, 8'hc6);
    chk("foreign ack", 2'h0, ak);
    chk("foreign meas", {1'h0, 2'h1, 2'h3, 1'h1, 1'h1}, meas);
    send_cmd(TGT, 8'h46);
    chk("func 01 ack", 2'h3, ak);
    chk("func 01 meas", {1'h0, 2'h1, 2'h3, 1'h1, 1'h1}, meas);
  endtask : t_foreign
  initial begin
    rst = 1'b1;
    done = 1'b0;
    sample = 16'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_measure();
    t_sleep();
    t_trim();
    t_read();
    t_foreign();
    print_verdict();
  end
endmodule : alsicp_top_bench
